// [rtl/foc_map.vh]
// Register map, field positions, reset values and time base constants
// for the oscillator offset compensation block.
// Assumes a byte-wide register port and a nominal 32.768 kHz oscillator.
`ifndef FOC_MAP_VH
`define FOC_MAP_VH

// Register offset and reset value
`define FOC_ADDR_FREQ_CORR   8'h02
`define FOC_FREQ_CORR_RST    8'h00

// Field layout of frequency_correction
`define FOC_MODE_BIT         7
`define FOC_OFFS_MSB         6
`define FOC_OFFS_LSB         0

// Time base, printed figures in their own units
`define FOC_OSC_HZ           32768
`define FOC_NORM_PERIOD_S    7200
`define FOC_FAST_PERIOD_S    240

// Step size per LSB in units of 0.001 ppm (informational)
`define FOC_PPM_NORM_MILLI   4340
`define FOC_PPM_FAST_MILLI   4069

// Compensated ticks per half period of the 1 Hz output
`define FOC_HALF_SEC_TICKS   16384

// Widths
`define FOC_PERIOD_W         28
`define FOC_PRESC_W          14
`define FOC_PEND_W           7

`endif

// [rtl/foc_pin_sync.v]
// Two-stage synchroniser with rising edge detect for the oscillator pin.
// Assumes the pin toggles far slower than clk.
`timescale 1ns/10ps
module foc_pin_sync
(
   clk,
   reset_n,
   pin_in,
   rise_pulse
);
   input  wire clk;
   input  wire reset_n;
   input  wire pin_in;
   output wire rise_pulse;

   reg         meta_ff;
   reg         sync_ff;
   reg         prev_ff;

   ////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second stage
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign rise_pulse = sync_ff & ~prev_ff;

endmodule // foc_pin_sync

// [rtl/foc_comp_core.v]
// Oscillator offset compensation: one byte register with a mode bit and
// a signed correction value; inserts or removes timekeeping ticks once
// per correction period and derives the 1 Hz clock output from them.
// Assumes osc_in is the raw 32.768 kHz oscillator, asynchronous to clk,
// and that the serial host front end drives the byte register port.
//
// Contract
// R1: Correction runs every two hours with mode 0, every 4 minutes with 1.
// R2: Bits 6 to 0 are a two's complement step count, -64 to +63.
// R3: Normal mode step shifts output frequency 4.34 ppm at 32.768 kHz; code adds or removes one tick per 7200 s, about 0.0042 ppm.
// R4: Fast mode step shifts output frequency 4.069 ppm at 32.768 kHz; code adds or removes one tick per 240 s, about 0.127 ppm.
// R5: Issue signed pulse count equal to value; +63 adds, -1 removes one.
// R6: New settings apply at next correction instant, never mid-correction.
`timescale 1ns/10ps
`include "foc_map.vh"
module foc_comp_core
#(
   parameter NORM_TICKS = `FOC_NORM_PERIOD_S * `FOC_OSC_HZ,
   parameter FAST_TICKS = `FOC_FAST_PERIOD_S * `FOC_OSC_HZ
)
(
   clk,
   reset_n,
   osc_in,
   reg_addr,
   reg_wr_en,
   reg_rd_en,
   reg_wdata,
   reg_rdata,
   comp_tick,
   clock_output_pin,
   comp_busy
);
   input  wire       clk;
   input  wire       reset_n;
   input  wire       osc_in;
   input  wire [7:0] reg_addr;
   input  wire       reg_wr_en;
   input  wire       reg_rd_en;
   input  wire [7:0] reg_wdata;
   output wire [7:0] reg_rdata;
   output wire       comp_tick;
   output wire       clock_output_pin;
   output wire       comp_busy;

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ADD  = 2'h1;
   localparam [1:0] ST_SUB  = 2'h2;

   // Terminal counts worked out at full width, then cut to the counters
   localparam integer NORM_LAST_I  = NORM_TICKS - 1;
   localparam integer FAST_LAST_I  = FAST_TICKS - 1;
   localparam integer PRESC_LAST_I = `FOC_HALF_SEC_TICKS - 1;
   localparam [`FOC_PERIOD_W-1:0] NORM_LAST =
      NORM_LAST_I[`FOC_PERIOD_W-1:0];
   localparam [`FOC_PERIOD_W-1:0] FAST_LAST =
      FAST_LAST_I[`FOC_PERIOD_W-1:0];
   localparam [`FOC_PRESC_W-1:0] PRESC_LAST =
      PRESC_LAST_I[`FOC_PRESC_W-1:0];

   reg  [7:0]               freq_corr_ff;
   reg  [7:0]               rdata_ff;
   reg                      act_mode_ff;
   reg  [`FOC_PERIOD_W-1:0] period_cnt_ff;
   reg  [`FOC_PERIOD_W-1:0] nxt_period_cnt;
   reg  [1:0]               state_ff;
   reg  [1:0]               nxt_state;
   reg  [`FOC_PEND_W-1:0]   pend_ff;
   reg  [`FOC_PEND_W-1:0]   nxt_pend;
   reg                      tick_dly_ff;
   reg                      comp_tick_ff;
   reg                      nxt_comp_tick;
   reg  [`FOC_PRESC_W-1:0]  presc_ff;
   reg                      clk_out_ff;
   wire                     osc_tick;
   wire                     period_end;
   wire [`FOC_PERIOD_W-1:0] period_last;

   // Magnitude of a two's complement step count, 1 to 64 for negatives
   function [`FOC_PEND_W-1:0] step_mag;
      input [`FOC_OFFS_MSB:`FOC_OFFS_LSB] val;
      begin
         if (val[`FOC_OFFS_MSB])
            step_mag = (~val) + 7'h01;
         else
            step_mag = val;
      end
   endfunction

   // Address decode, shared by the write and the read path
   function is_corr_addr;
      input [7:0] addr;
      begin
         is_corr_addr = (addr == `FOC_ADDR_FREQ_CORR);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Oscillator pin, synchronised before use
   foc_pin_sync u_osc_sync
   (
      .clk        (clk),
      .reset_n    (reset_n),
      .pin_in     (osc_in),
      .rise_pulse (osc_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register port
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         freq_corr_ff <= `FOC_FREQ_CORR_RST;
         rdata_ff     <= 8'h00;
      end
      else
      begin
         if (reg_wr_en && is_corr_addr(reg_addr))
            freq_corr_ff <= reg_wdata;
         if (reg_rd_en)
         begin
            if (is_corr_addr(reg_addr))
               rdata_ff <= freq_corr_ff;
            else
               rdata_ff <= 8'h00;
         end
      end
   end

   assign reg_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////
   // Correction period, counted in raw oscillator ticks so the schedule
   // itself is not bent by the correction it applies
   assign period_last = act_mode_ff ? FAST_LAST : NORM_LAST; // R1
   assign period_end  = osc_tick && (period_cnt_ff == period_last); // R1

   always @*
   begin
      nxt_period_cnt = period_cnt_ff;
      if (period_end)
         nxt_period_cnt = {`FOC_PERIOD_W{1'b0}};
      else if (osc_tick)
         nxt_period_cnt = period_cnt_ff + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse engine: positive values add ticks, negative values swallow
   always @*
   begin
      nxt_state     = state_ff;
      nxt_pend      = pend_ff;
      nxt_comp_tick = osc_tick;
      case (state_ff)
         ST_IDLE:
         begin
            if (period_end &&
                (freq_corr_ff[`FOC_OFFS_MSB:`FOC_OFFS_LSB] != 7'h00))
            begin
               nxt_pend = step_mag(freq_corr_ff[`FOC_OFFS_MSB:`FOC_OFFS_LSB]); // R2 R6
               if (freq_corr_ff[`FOC_OFFS_MSB])
                  nxt_state = ST_SUB; // R5
               else
                  nxt_state = ST_ADD; // R5
            end
         end
         ST_ADD:
         begin
            // Extra tick sits one cycle after a real one, never on top
            if (tick_dly_ff)
            begin
               nxt_comp_tick = 1'b1; // R5
               nxt_pend      = pend_ff - 1'b1;
               if (pend_ff == 7'h01)
                  nxt_state = ST_IDLE;
            end
         end
         ST_SUB:
         begin
            if (osc_tick)
            begin
               nxt_comp_tick = 1'b0; // R5
               nxt_pend      = pend_ff - 1'b1;
               if (pend_ff == 7'h01)
                  nxt_state = ST_IDLE;
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
            nxt_pend  = {`FOC_PEND_W{1'b0}};
         end
      endcase
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         act_mode_ff   <= 1'b0;
         period_cnt_ff <= {`FOC_PERIOD_W{1'b0}};
         state_ff      <= ST_IDLE;
         pend_ff       <= {`FOC_PEND_W{1'b0}};
         tick_dly_ff   <= 1'b0;
         comp_tick_ff  <= 1'b0;
      end
      else
      begin
         // Mode only changes at an instant, so a new write cannot
         // stretch or cut the period now running
         if (period_end)
            act_mode_ff <= freq_corr_ff[`FOC_MODE_BIT]; // R6 R1
         period_cnt_ff <= nxt_period_cnt;
         state_ff      <= nxt_state;
         pend_ff       <= nxt_pend;
         tick_dly_ff   <= osc_tick;
         comp_tick_ff  <= nxt_comp_tick;
      end
   end

   assign comp_tick = comp_tick_ff;
   assign comp_busy = (state_ff != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // 1 Hz output from compensated ticks; one tick per period shifts it by
   // one step, hence the ppm size follows the period length
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         presc_ff   <= {`FOC_PRESC_W{1'b0}};
         clk_out_ff <= 1'b0;
      end
      else if (comp_tick_ff)
      begin
         if (presc_ff == PRESC_LAST)
         begin
            presc_ff   <= {`FOC_PRESC_W{1'b0}};
            clk_out_ff <= ~clk_out_ff; // R3 R4
         end
         else
            presc_ff <= presc_ff + 1'b1;
      end
   end

   assign clock_output_pin = clk_out_ff;

endmodule // foc_comp_core

// [dv/foc_comp_core_properties.sv]
// Port checker for the offset compensation core.
// Assumes the bind at the foot; sees the top ports only.
`timescale 1ns/10ps
module foc_properties
#(
   parameter NORM_TICKS = 80,
   parameter FAST_TICKS = 70
)
(
   input wire       clk,
   input wire       reset_n,
   input wire       osc_in,
   input wire [7:0] reg_addr,
   input wire       reg_wr_en,
   input wire       reg_rd_en,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire       comp_tick,
   input wire       clock_output_pin,
   input wire       comp_busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_wr;
      reg_wr_en && reg_addr == 8'h02;
   endsequence
   sequence s_rd;
      reg_rd_en && !reg_wr_en && reg_addr == 8'h02;
   endsequence
   sequence s_dbl;
      comp_tick ##1 comp_tick;
   endsequence
   AST_RD_BACK: assert property (s_wr ##1 s_rd |=>
      reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
   AST_RD_UNMAP: assert property (reg_rd_en && reg_addr != 8'h02
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   AST_RD_HOLD: assert property (!reg_rd_en |=> $stable(reg_rdata))
      else $error("read data moved");
   AST_RD_STABLE: assert property (s_rd ##1 s_rd |=> $stable(reg_rdata))
      else $error("register changed without write");
   AST_TICK_MAX2: assert property (s_dbl |=> !comp_tick)
      else $error("three ticks in a row");
   AST_DBL_BUSY: assert property (s_dbl |-> $past(comp_busy))
      else $error("extra tick outside correction");
   AST_BUSY_START: assert property ($rose(comp_busy) |-> comp_tick)
      else $error("correction started off a tick");
   AST_OUT_EDGE: assert property ($changed(clock_output_pin) |->
      comp_tick || $past(comp_tick) || $past(comp_tick, 2))
      else $error("output toggled without tick");
endmodule // foc_properties

bind foc_comp_core foc_properties
#(
   .NORM_TICKS       (NORM_TICKS),
   .FAST_TICKS       (FAST_TICKS)
)
u_props
(
   .clk              (clk),
   .reset_n          (reset_n),
   .osc_in           (osc_in),
   .reg_addr         (reg_addr),
   .reg_wr_en        (reg_wr_en),
   .reg_rd_en        (reg_rd_en),
   .reg_wdata        (reg_wdata),
   .reg_rdata        (reg_rdata),
   .comp_tick        (comp_tick),
   .clock_output_pin (clock_output_pin),
   .comp_busy        (comp_busy)
);

// [dv/foc_comp_core_test.sv]
// Self-checking bench for the offset compensation core.
// Assumes a fast stand-in oscillator of 16 clk per tick.
`timescale 1ns/10ps
module foc_comp_core_test;
   logic        clk, reset_n, osc_in, reg_wr_en, reg_rd_en;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, v1, v2;
   logic        comp_tick, clock_output_pin, comp_busy;
   logic [15:0] ncomp;
   int          err_total, n_checks, t;
   foc_comp_core
   #(
      .NORM_TICKS       (80),
      .FAST_TICKS       (70)
   )
   dut
   (
      .clk              (clk),
      .reset_n          (reset_n),
      .osc_in           (osc_in),
      .reg_addr         (reg_addr),
      .reg_wr_en        (reg_wr_en),
      .reg_rd_en        (reg_rd_en),
      .reg_wdata        (reg_wdata),
      .reg_rdata        (reg_rdata),
      .comp_tick        (comp_tick),
      .clock_output_pin (clock_output_pin),
      .comp_busy        (comp_busy)
   );
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk or negedge reset_n)
      if (!reset_n) ncomp <= 16'h0000;
      else if (comp_tick) ncomp <= ncomp + 16'h0001;
   ////////////////////////////////////////////////////////////
   task chk(input string nm, input [15:0] got, input [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s exp %h seen %h", nm, exp, got);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      reg_addr  <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      @(posedge clk) #1;
      chk("rdata", {8'h00, reg_rdata}, {8'h00, exp});
      @(posedge clk);
   endtask
   // Counts always include the first correction, the second only when a selects fast mode
   function [15:0] expc(input [7:0] a, input [7:0] b);
      expc = 16'd159 + {{9{a[6]}}, a[6:0]}
           + (a[7] ? {{9{b[6]}}, b[6:0]} : 16'd0);
   endfunction
   // Still correcting just after tick 85: an addition starts on the
   // instant tick itself, a removal on the tick after it
   function [15:0] expb(input [7:0] a);
      expb = {15'h0000,
              ($signed(a[6:0]) >= 7) || ($signed(a[6:0]) <= -6)};
   endfunction
   task run(input [7:0] a, input [7:0] b);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(8'h02, 8'h00);
      wr(8'h02, a);
      rd(8'h02, a);
      for (int i = 1; i <= 159; i++)
      begin
         osc_in <= 1'b1;
         repeat (8) @(posedge clk);
         osc_in <= 1'b0;
         repeat (6) @(posedge clk);
         // Rewrite lands mid-correction when a is 7 or more or -6 or less; must wait for the next instant
         if (i == 85)
         begin
            chk("busy", {15'h0000, comp_busy}, expb(a));
            wr(8'h02, b);
         end
         else
            @(posedge clk);
         @(posedge clk);
      end
      #1;
      chk("ticks", ncomp, expc(a, b));
      chk("idle", {15'h0000, comp_busy}, 16'h0000);
      // Far fewer than 16384 ticks per run, so the output stays low
      chk("clock_output_pin", {15'h0000, clock_output_pin}, 16'h0000);
      @(posedge clk);
      wr(8'h05, 8'hff);
      rd(8'h05, 8'h00);
      rd(8'h02, b);
      reg_rd_en <= 1'b1;
      repeat (2) @(posedge clk);
      reg_rd_en <= 1'b0;
      $display("test done %h %h", a, b);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin #400000; err_total++; give_verdict; end
   initial
   begin
      {reset_n, osc_in, reg_wr_en, reg_rd_en} = 4'h0;
      {reg_addr, reg_wdata} = 16'h0000;
      err_total = 0;
      n_checks = 0;
      void'($urandom(32'h2126f081));
      @(posedge clk);
      foreach (v1[k]) run({1'b0, 7'h3f}, 8'h08);
      run(8'h40, 8'h78);
      run(8'hbf, 8'h78);
      run(8'hc0, 8'h08);
      run(8'hff, 8'h00);
      run(8'h81, 8'h7f);
      for (t = 0; t < 4; t++)
      begin
         v1 = $urandom;
         v2 = 8'($urandom % 17) - 8'h08;
         run(v1, v2);
      end
      give_verdict;
   end
endmodule // foc_comp_core_test
